// ==== pkg/tape_cmd_pkg.sv ====
// Constants shared by the tape formatter command port
package tape_cmd_pkg;

  // Bus and register map (byte addresses)
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] CMD_OFS = 4'h8;

  // Control register fields and reset value
  localparam int CTRL_EXT_PAR_POS = 0;
  localparam int CTRL_EXT_DEN_POS = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status register fields
  localparam int ST_BUSY_POS = 0;
  localparam int ST_SEL_POS = 1;
  localparam int ST_STRAP_POS = 2;
  localparam int ST_RUN_POS = 3;
  localparam int ST_LAST_POS = 4;
  localparam int ST_DRIVE_POS = 8;

  // Latched command fields
  localparam int CMD_W = 10;
  localparam int CMD_REV = 0;
  localparam int CMD_WRT = 1;
  localparam int CMD_WFM = 2;
  localparam int CMD_EDIT = 3;
  localparam int CMD_ERASE = 4;
  localparam int CMD_THR2 = 5;
  localparam int CMD_THR1 = 6;
  localparam int CMD_DEN = 7;
  localparam int CMD_PAR = 8;
  localparam int CMD_SEARCH = 9;
  localparam logic [CMD_W-1:0] CMD_RESET = 10'h000;

  // Timing: least interface pulse width
  localparam int CLK_PERIOD_NS = 20;
  localparam int PULSE_MIN_NS = 1000;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Command sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_RUN,
    SEQ_STOP
  } seq_state_e;

endpackage : tape_cmd_pkg

// ==== hw/tape_formatter_command_port.sv ====
// Controller-facing command and write-data port of a dual-mode tape formatter
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Respond only when select matches strap address
// - Decode two address lines to one transport
// - Latch command lines on initiate trailing edge
// - Ready at initiate: accept, assert busy
// - Direction bit: reverse when set, else forward
// - Write bit: write when set, else read
// - File mark plus write records file mark
// - File mark alone searches; ends at file mark, or at load point in reverse
// - Edit in read reverse modifies stop delay
// - Edit plus write drives overwrite output
// - Erase plus write: dummy write until last
// - Erase, write, file mark: fixed erase
// - Threshold bits choose extra low, or high with a single-gap head
// - Seven-track density bit selects lower density
// - Seven-track parity bit selects even parity
// - Rewind, offline pulses pass through, no busy
// - Enable negated resets formatter, select ignored
// - Line 0 MSB; seven-track drops two MSBs
// - Internal parity from data and mode
// - One strobe per character samples data
// - Busy holds until tape motion stops

module tape_formatter_command_port
  import tape_cmd_pkg::*;
#(
  parameter int PULSE_CYC = tape_cmd_pkg::PULSE_MIN_CYC
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Avalon-MM slave
  input wire logic [tape_cmd_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Strap
  input wire logic strap_addr_one,
  // Controller command lines (low true)
  input wire logic formatter_select_n,
  input wire logic drive_addr_bit0_n,
  input wire logic drive_addr_bit1_n,
  input wire logic command_initiate_pulse_n,
  input wire logic reverse_direction_bit_n,
  input wire logic write_select_bit_n,
  input wire logic file_mark_bit_n,
  input wire logic edit_bit_n,
  input wire logic erase_bit_n,
  input wire logic extra_low_threshold_bit_n,
  input wire logic high_threshold_bit_n,
  input wire logic density_low_bit_n,
  input wire logic parity_even_bit_n,
  input wire logic tape_rewind_pulse_n,
  input wire logic offline_unload_pulse_n,
  input wire logic formatter_enable_level_n,
  // Controller write data (low true)
  input wire logic last_char_flag_n,
  input wire logic [0:7] write_char_lines_n,
  input wire logic write_parity_line_n,
  // Controller outputs (low true)
  output logic formatter_busy_n,
  output logic write_char_strobe_n,
  // Transport and tape logic status (active high)
  input wire logic transport_ready,
  input wire logic seven_track,
  input wire logic single_gap_head,
  input wire logic motion_stopped,
  input wire logic char_request,
  input wire logic op_done,
  input wire logic file_mark_found,
  input wire logic load_point,
  // Transport outputs (low true)
  output logic [3:0] drive_select_n,
  output logic fwd_motion_n,
  output logic rev_motion_n,
  output logic set_write_n,
  output logic overwrite_out_n,
  output logic rewind_cmd_n,
  output logic offline_cmd_n,
  output logic extra_low_thr_n,
  output logic high_thr_n,
  output logic density_low_n,
  output logic parity_even_n,
  // Write and read logic controls (active high)
  output logic [8:0] write_word,
  output logic write_word_valid,
  output logic write_word_last,
  output logic dummy_write,
  output logic file_mark_write,
  output logic fixed_erase,
  output logic file_search,
  output logic edit_stop_delay
);
  import tape_cmd_pkg::*;

  if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_bad_pulse
    $error("PULSE_CYC out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State declarations
  seq_state_e state_reg, state_next;
  logic [CMD_W-1:0] cmd_reg;
  logic [1:0] ctrl_reg;
  logic strap_reg;
  logic strap_done_reg;
  logic go_prev_reg;
  logic [7:0] strobe_cnt_reg;
  logic strobe_on_reg;
  logic last_seen_reg;
  logic busy_reg;
  logic [3:0] drive_sel_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic rew_reg;
  logic ofl_reg;
  logic fwd_reg;
  logic rev_reg;
  logic [8:0] word_reg;
  logic word_valid_reg;
  logic word_last_reg;
  logic [7:0] xport_reg;
  logic [4:0] mode_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Input decode
  wire enabled = ~formatter_enable_level_n;
  wire go_act = ~command_initiate_pulse_n;
  wire go_trail = go_prev_reg & ~go_act;
  wire addr_match = (~formatter_select_n) == strap_reg;
  wire [1:0] drive_addr = {~drive_addr_bit1_n, ~drive_addr_bit0_n};
  wire [3:0] drive_dec = 4'h1 << drive_addr;
  wire ready = (state_reg == SEQ_IDLE) && transport_ready && strap_done_reg;
  wire accept = go_trail && addr_match && ready && enabled;
  wire [CMD_W-1:0] cmd_in = {
    ~file_mark_bit_n & write_select_bit_n,
    ~parity_even_bit_n, ~density_low_bit_n, ~high_threshold_bit_n,
    ~extra_low_threshold_bit_n, ~erase_bit_n, ~edit_bit_n,
    ~file_mark_bit_n, ~write_select_bit_n, ~reverse_direction_bit_n
  };
  wire is_wrt = cmd_reg[CMD_WRT];
  wire is_rev = cmd_reg[CMD_REV];
  wire is_search = cmd_reg[CMD_SEARCH];
  wire is_erase = cmd_reg[CMD_ERASE] & is_wrt;

  ////////////////////////////////////////////////////////////////////////////
  // Write data path
  wire [7:0] line_data = ~write_char_lines_n; // Line 0 lands in bit 7
  wire [7:0] char_data = seven_track ? (line_data & 8'h3F) : line_data;
  wire even_mode = seven_track & cmd_reg[CMD_PAR];
  wire gen_parity = even_mode ? (^char_data) : ~(^char_data);
  wire ext_par = ctrl_reg[CTRL_EXT_PAR_POS];
  wire parity_bit = ext_par ? ~write_parity_line_n : gen_parity;
  wire strobe_end = strobe_on_reg && (strobe_cnt_reg == 8'(PULSE_CYC - 1));
  wire strobe_start = (state_reg == SEQ_RUN) && is_wrt && char_request
    && !strobe_on_reg && !last_seen_reg && !cmd_reg[CMD_WFM];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  wire run_end = is_search ? (file_mark_found || (is_rev && load_point)) : op_done;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SEQ_IDLE: begin
        if (accept) begin
          state_next = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (run_end) begin
          state_next = SEQ_STOP;
        end
      end
      SEQ_STOP: begin
        if (motion_stopped) begin
          state_next = SEQ_IDLE;
        end
      end
      default: begin
        state_next = SEQ_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode
  wire bus_req = avs_read | avs_write;
  wire bus_done = bus_req & ~wait_reg;
  wire hit_ctrl = avs_address == CTRL_OFS;
  wire hit_status = avs_address == STATUS_OFS;
  wire hit_cmd = avs_address == CMD_OFS;
  wire ctrl_wr = bus_done & avs_write & hit_ctrl & avs_byteenable[0];
  wire [31:0] status_word = (32'(drive_sel_reg) << ST_DRIVE_POS)
    | (32'(last_seen_reg) << ST_LAST_POS)
    | (32'(state_reg == SEQ_RUN) << ST_RUN_POS)
    | (32'(strap_reg) << ST_STRAP_POS)
    | (32'(addr_match) << ST_SEL_POS)
    | (32'(busy_reg) << ST_BUSY_POS);
  wire [31:0] read_mux = hit_ctrl ? 32'(ctrl_reg)
    : hit_status ? status_word
    : hit_cmd ? 32'(cmd_reg)
    : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      ctrl_reg <= CTRL_RESET;
    end else if (clk_en) begin
      wait_reg <= ~(bus_req & wait_reg);
      if (bus_req & wait_reg) begin
        rdata_reg <= read_mux;
      end
      if (ctrl_wr) begin
        ctrl_reg <= avs_writedata[1:0];
      end
    end
  end

  // Strap caught once after reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_reg <= 1'b0;
      strap_done_reg <= 1'b0;
    end else if (clk_en && !strap_done_reg) begin
      strap_reg <= strap_addr_one;
      strap_done_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command latch and sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SEQ_IDLE;
      cmd_reg <= CMD_RESET;
      busy_reg <= 1'b0;
      go_prev_reg <= 1'b0;
    end else if (clk_en) begin
      go_prev_reg <= go_act;
      if (!enabled) begin
        state_reg <= SEQ_IDLE;
        busy_reg <= 1'b0;
      end else begin
        state_reg <= state_next;
        busy_reg <= (state_next != SEQ_IDLE);
        if (accept) begin
          cmd_reg <= cmd_in;
        end
      end
    end
  end

  // Drive select follows the address lines while addressed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_sel_reg <= 4'h1;
    end else if (clk_en && addr_match) begin
      drive_sel_reg <= drive_dec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pass-through rewind and off-line pulses, no busy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rew_reg <= 1'b0;
      ofl_reg <= 1'b0;
    end else if (clk_en) begin
      rew_reg <= ~tape_rewind_pulse_n & addr_match & enabled;
      ofl_reg <= ~offline_unload_pulse_n & addr_match & enabled;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write strobe generation and character capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_on_reg <= 1'b0;
      strobe_cnt_reg <= 8'h00;
      last_seen_reg <= 1'b0;
      word_reg <= 9'h000;
      word_valid_reg <= 1'b0;
      word_last_reg <= 1'b0;
    end else if (clk_en) begin
      word_valid_reg <= 1'b0;
      word_last_reg <= 1'b0;
      if (!enabled || accept) begin
        strobe_on_reg <= 1'b0;
        strobe_cnt_reg <= 8'h00;
        last_seen_reg <= 1'b0;
      end else if (strobe_start) begin
        strobe_on_reg <= 1'b1;
        strobe_cnt_reg <= 8'h00;
      end else if (strobe_end) begin
        strobe_on_reg <= 1'b0;
        word_reg <= {parity_bit, char_data};
        word_valid_reg <= 1'b1;
        word_last_reg <= ~last_char_flag_n;
        last_seen_reg <= ~last_char_flag_n;
      end else if (strobe_on_reg) begin
        strobe_cnt_reg <= strobe_cnt_reg + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transport levels and mode outputs, registered from the latched command
  wire cmd_next_rev = accept ? cmd_in[CMD_REV] : is_rev;
  wire [7:0] xport_next = {
    1'b0,
    is_wrt,
    cmd_reg[CMD_EDIT] & is_wrt,
    cmd_reg[CMD_THR2],
    cmd_reg[CMD_THR1] & single_gap_head,
    cmd_reg[CMD_DEN] & seven_track & ctrl_reg[CTRL_EXT_DEN_POS],
    even_mode,
    1'b0
  };
  wire [4:0] mode_next = {
    is_erase & ~cmd_reg[CMD_WFM],
    cmd_reg[CMD_WFM] & is_wrt & ~is_erase,
    is_erase & cmd_reg[CMD_WFM],
    is_search,
    cmd_reg[CMD_EDIT] & is_rev & ~is_wrt
  };

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_reg <= 1'b0;
      rev_reg <= 1'b0;
      xport_reg <= 8'h00;
      mode_reg <= 5'h00;
    end else if (clk_en) begin
      fwd_reg <= (state_next == SEQ_RUN) && enabled && !cmd_next_rev;
      rev_reg <= (state_next == SEQ_RUN) && enabled && cmd_next_rev;
      xport_reg <= xport_next;
      mode_reg <= mode_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output assignments
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign formatter_busy_n = ~busy_reg;
  assign write_char_strobe_n = ~strobe_on_reg;
  assign drive_select_n = ~drive_sel_reg;
  assign fwd_motion_n = ~fwd_reg;
  assign rev_motion_n = ~rev_reg;
  assign set_write_n = ~xport_reg[6];
  assign overwrite_out_n = ~xport_reg[5];
  assign extra_low_thr_n = ~xport_reg[4];
  assign high_thr_n = ~xport_reg[3];
  assign density_low_n = ~xport_reg[2];
  assign parity_even_n = ~xport_reg[1];
  assign rewind_cmd_n = ~rew_reg;
  assign offline_cmd_n = ~ofl_reg;
  assign write_word = word_reg;
  assign write_word_valid = word_valid_reg;
  assign write_word_last = word_last_reg;
  assign dummy_write = mode_reg[4];
  assign file_mark_write = mode_reg[3];
  assign fixed_erase = mode_reg[2];
  assign file_search = mode_reg[1];
  assign edit_stop_delay = mode_reg[0];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [7:0] low_len_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_len_reg <= 8'h00;
    end else if (clk_en) begin
      low_len_reg <= strobe_on_reg ? low_len_reg + 8'h01 : 8'h00;
    end
  end

  sequence s_accept;
    clk_en && accept;
  endsequence

  a_busy_on_accept: assert property (s_accept |=> busy_reg && state_reg == SEQ_RUN)
    else $error("busy not set after accepted initiate");
  a_latch_on_accept: assert property (s_accept |=> cmd_reg == $past(cmd_in))
    else $error("command not latched on initiate");
  a_ignore_not_ready: assert property (clk_en && go_trail && !ready |=> $stable(cmd_reg) && $stable(busy_reg))
    else $error("initiate taken while not ready");
  a_addr_mismatch: assert property (clk_en && go_trail && !addr_match && !busy_reg |=> !busy_reg)
    else $error("busy set for another formatter");
  a_one_drive: assert property ($onehot(drive_sel_reg))
    else $error("drive select not one-hot");
  a_enable_reset: assert property (clk_en && !enabled |=> state_reg == SEQ_IDLE && !busy_reg)
    else $error("enable low did not clear formatter");
  a_rewind_pass: assert property (clk_en && !tape_rewind_pulse_n && addr_match && enabled && !busy_reg
    |=> rew_reg && !busy_reg)
    else $error("rewind not passed through or busy set");
  a_strobe_width: assert property (clk_en && strobe_on_reg && strobe_end |-> low_len_reg == 8'(PULSE_CYC - 1))
    else $error("write strobe width wrong");
  a_parity_gen: assert property (clk_en && strobe_end && !ext_par |=> word_valid_reg
    && (word_reg[8] == (even_mode ? ^word_reg[7:0] : ~(^word_reg[7:0]))))
    else $error("generated parity wrong");
  a_search_end: assert property (clk_en && state_reg == SEQ_RUN && is_search && file_mark_found
    |=> state_reg == SEQ_STOP && !fwd_reg && !rev_reg)
    else $error("file search did not stop on file mark");
  a_overwrite_out: assert property (clk_en && cmd_reg[CMD_EDIT] && is_wrt |=> xport_reg[5])
    else $error("overwrite not driven for edit write");

endmodule : tape_formatter_command_port
`default_nettype wire

// ==== tb/tape_host_model.sv ====
// Host controller model driving command, pass-through and write-data lines
`timescale 1ns/10ps
`default_nettype none
module tape_host_model #(
  parameter int PW = 3
) (
  // Clock and formatter strobe
  input wire logic clk,
  input wire logic write_char_strobe_n,
  // Command lines, low true
  output logic formatter_select_n,
  output logic [1:0] drive_addr_n,
  output logic command_initiate_pulse_n,
  output logic [8:0] cmd_n,
  output logic tape_rewind_pulse_n,
  output logic offline_unload_pulse_n,
  output logic formatter_enable_level_n,
  // Write data lines, low true
  output logic last_char_flag_n,
  output logic [7:0] char_n,
  output logic write_parity_line_n
);
  logic [8:0] q [2];
  int n;
  int idx;
  int li;
  logic strobe_q;

  // Idle levels
  initial begin
    q = '{9'h000, 9'h000};
    n = 0;
    idx = 0;
    strobe_q = 1'b1;
    formatter_select_n = 1'b1;
    drive_addr_n = 2'h3;
    command_initiate_pulse_n = 1'b1;
    cmd_n = 9'h1FF;
    tape_rewind_pulse_n = 1'b1;
    offline_unload_pulse_n = 1'b1;
    formatter_enable_level_n = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Released lines show the inverse of the last value
  assign li = (n > 0) ? n - 1 : 0;
  assign char_n = (idx < n) ? ~q[idx][7:0] : q[li][7:0];
  assign write_parity_line_n = (idx < n) ? ~q[idx][8] : q[li][8];
  assign last_char_flag_n = !(idx == n - 1);

  // Next character one cycle after each strobe trailing edge
  always @(posedge clk) begin
    strobe_q <= write_char_strobe_n;
    if (!strobe_q && write_char_strobe_n) idx <= idx + 1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Queue up to two characters ahead of the strobes
  task automatic load(input logic [8:0] a, input logic [8:0] b, input int cnt);
    q[0] <= a;
    q[1] <= b;
    n <= cnt;
    idx <= 0;
    @(posedge clk);
  endtask : load

  // Command: set levels, initiate pulse, hold past trailing edge
  task automatic go(input logic [8:0] cmd, input logic sel, input logic [1:0] drv);
    @(posedge clk);
    formatter_select_n <= ~sel;
    drive_addr_n <= ~drv;
    cmd_n <= ~cmd;
    repeat (PW) @(posedge clk);
    command_initiate_pulse_n <= 1'b0;
    repeat (PW) @(posedge clk);
    command_initiate_pulse_n <= 1'b1;
    repeat (PW) @(posedge clk);
  endtask : go

  // Pulse 0 rewind, 1 offline, 2 enable negated with the other address
  task automatic pulse(input int which);
    @(posedge clk);
    formatter_select_n <= (which == 2);
    tape_rewind_pulse_n <= (which != 0);
    offline_unload_pulse_n <= (which != 1);
    formatter_enable_level_n <= (which == 2);
    repeat (PW) @(posedge clk);
    tape_rewind_pulse_n <= 1'b1;
    offline_unload_pulse_n <= 1'b1;
    formatter_enable_level_n <= 1'b0;
  endtask : pulse
endmodule : tape_host_model
`default_nettype wire

// ==== tb/test_tape_formatter_command_port.sv ====
// Self-checking bench for the tape formatter command port
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_tape_formatter_command_port;
  import tape_cmd_pkg::*;
  localparam int PW = 3;
  localparam logic [8:0] CMDS [9] = '{9'h000, 9'h009, 9'h00A, 9'h006, 9'h004, 9'h012, 9'h016, 9'h025, 9'h1E0};
  localparam logic [12:0] MASKS [9] = '{13'h0007, 13'h010F, 13'h000F, 13'h00F4, 13'h00B4, 13'h0060, 13'h0040,
    13'h0600, 13'h1E00};
  localparam logic [12:0] EXPS [9] = '{13'h0001, 13'h0102, 13'h000D, 13'h0014, 13'h0080, 13'h0020, 13'h0040,
    13'h0200, 13'h1E00};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic transport_ready = 1'b1;
  logic seven_track = 1'b0;
  logic motion_stopped = 1'b0;
  logic char_request = 1'b0;
  logic op_done = 1'b0;
  logic file_mark_found = 1'b0;
  logic load_point = 1'b0;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, formatter_busy_n, write_char_strobe_n, fwd_motion_n, rev_motion_n, set_write_n;
  logic overwrite_out_n, rewind_cmd_n, offline_cmd_n, extra_low_thr_n, high_thr_n, density_low_n;
  logic parity_even_n, write_word_valid, write_word_last, dummy_write, file_mark_write, fixed_erase;
  logic file_search, edit_stop_delay, formatter_select_n, command_initiate_pulse_n, tape_rewind_pulse_n;
  logic offline_unload_pulse_n, formatter_enable_level_n, last_char_flag_n, write_parity_line_n;
  logic [3:0] drive_select_n;
  logic [8:0] write_word;
  logic [1:0] drive_addr_n;
  logic [8:0] cmd_n;
  logic [7:0] char_n;
  logic [12:0] mode_vec;

  // Observed modes, active high
  assign mode_vec = {~parity_even_n, ~density_low_n, ~high_thr_n, ~extra_low_thr_n, edit_stop_delay, file_search,
    fixed_erase, dummy_write, file_mark_write, ~overwrite_out_n, ~set_write_n, ~rev_motion_n, ~fwd_motion_n};

  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Design and host model
  tape_formatter_command_port #(.PULSE_CYC(PW)) u_tape_formatter_command_port (
    .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .strap_addr_one(1'b1), .formatter_select_n(formatter_select_n),
    .drive_addr_bit0_n(drive_addr_n[0]), .drive_addr_bit1_n(drive_addr_n[1]),
    .command_initiate_pulse_n(command_initiate_pulse_n), .reverse_direction_bit_n(cmd_n[CMD_REV]),
    .write_select_bit_n(cmd_n[CMD_WRT]), .file_mark_bit_n(cmd_n[CMD_WFM]), .edit_bit_n(cmd_n[CMD_EDIT]),
    .erase_bit_n(cmd_n[CMD_ERASE]), .extra_low_threshold_bit_n(cmd_n[CMD_THR2]),
    .high_threshold_bit_n(cmd_n[CMD_THR1]), .density_low_bit_n(cmd_n[CMD_DEN]),
    .parity_even_bit_n(cmd_n[CMD_PAR]), .tape_rewind_pulse_n(tape_rewind_pulse_n),
    .offline_unload_pulse_n(offline_unload_pulse_n), .formatter_enable_level_n(formatter_enable_level_n),
    .last_char_flag_n(last_char_flag_n), .write_char_lines_n(char_n), .write_parity_line_n(write_parity_line_n),
    .formatter_busy_n(formatter_busy_n), .write_char_strobe_n(write_char_strobe_n),
    .transport_ready(transport_ready), .seven_track(seven_track), .single_gap_head(1'b1),
    .motion_stopped(motion_stopped), .char_request(char_request), .op_done(op_done),
    .file_mark_found(file_mark_found), .load_point(load_point), .drive_select_n(drive_select_n),
    .fwd_motion_n(fwd_motion_n), .rev_motion_n(rev_motion_n), .set_write_n(set_write_n),
    .overwrite_out_n(overwrite_out_n), .rewind_cmd_n(rewind_cmd_n), .offline_cmd_n(offline_cmd_n),
    .extra_low_thr_n(extra_low_thr_n), .high_thr_n(high_thr_n), .density_low_n(density_low_n),
    .parity_even_n(parity_even_n), .write_word(write_word), .write_word_valid(write_word_valid),
    .write_word_last(write_word_last), .dummy_write(dummy_write), .file_mark_write(file_mark_write),
    .fixed_erase(fixed_erase), .file_search(file_search), .edit_stop_delay(edit_stop_delay));

  tape_host_model #(.PW(PW)) u_tape_host_model (
    .clk(clk), .write_char_strobe_n(write_char_strobe_n), .formatter_select_n(formatter_select_n),
    .drive_addr_n(drive_addr_n), .command_initiate_pulse_n(command_initiate_pulse_n), .cmd_n(cmd_n),
    .tape_rewind_pulse_n(tape_rewind_pulse_n), .offline_unload_pulse_n(offline_unload_pulse_n),
    .formatter_enable_level_n(formatter_enable_level_n), .last_char_flag_n(last_char_flag_n),
    .char_n(char_n), .write_parity_line_n(write_parity_line_n));

  ////////////////////////////////////////////////////////////////////////
  // Bus cycles: hold request until waitrequest is sampled low
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus_rd

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus_wr

  // One character: count strobe width, check word
  task automatic send_char(input logic [8:0] e, input logic last);
    int lo;
    lo = 0;
    char_request <= 1'b1;
    @(posedge clk);
    char_request <= 1'b0;
    do begin
      @(posedge clk);
      if (write_char_strobe_n === 1'b0) lo++;
    end while (write_word_valid !== 1'b1);
    `CHK(lo, PW)
    `CHK(write_word, e)
    `CHK(write_word_last, last)
  endtask : send_char

  // End the run; busy must wait for motion to stop
  task automatic finish_op(input logic fm);
    op_done <= 1'b1;
    file_mark_found <= fm;
    load_point <= !fm;
    repeat (4) @(posedge clk);
    `CHK(formatter_busy_n, 1'b0)
    motion_stopped <= 1'b1;
    do @(posedge clk); while (formatter_busy_n !== 1'b1);
    {op_done, file_mark_found, load_point, motion_stopped} <= 4'h0;
    @(posedge clk);
  endtask : finish_op

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // Cycle ceiling against a hung wait
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      stop_test;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    logic [31:0] d;
    int lo;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(formatter_busy_n, 1'b1)
    `CHK(drive_select_n, 4'hE)
    bus_rd(CTRL_OFS, d);
    `CHK(d, 32'h0)
    bus_rd(STATUS_OFS, d);
    `CHK(d[ST_STRAP_POS], 1'b1)
    bus_rd(4'hC, d);
    `CHK(d, 32'h0)
    bus_wr(CTRL_OFS, 32'hFFFFFFFF);
    bus_rd(CTRL_OFS, d);
    `CHK(d, 32'h3)
    $display("test registers done");
    // Nine-track write, internal odd parity, two characters
    bus_wr(CTRL_OFS, 32'h0);
    u_tape_host_model.load(9'h0A5, 9'h03C, 2);
    u_tape_host_model.go(9'h002, 1'b1, 2'h0);
    `CHK(formatter_busy_n, 1'b0)
    bus_rd(CMD_OFS, d);
    `CHK(d[8:0], 9'h002)
    send_char({~^8'hA5, 8'hA5}, 1'b0);
    send_char({~^8'h3C, 8'h3C}, 1'b1);
    finish_op(1'b1);
    // Seven-track write with external parity line
    bus_wr(CTRL_OFS, 32'h3);
    seven_track <= 1'b1;
    u_tape_host_model.load(9'h1FF, 9'h000, 1);
    u_tape_host_model.go(9'h002, 1'b1, 2'h0);
    send_char(9'h13F, 1'b1);
    finish_op(1'b1);
    $display("test write done");
    // Command mode table over all drives
    bus_wr(CTRL_OFS, 32'h2);
    for (int i = 0; i < 9; i++) begin
      seven_track <= (i == 8);
      u_tape_host_model.go(CMDS[i], 1'b1, i[1:0]);
      repeat (2) @(posedge clk);
      `CHK(mode_vec & MASKS[i], EXPS[i])
      `CHK(drive_select_n, ~(4'h1 << i[1:0]))
      finish_op(i != 7);
    end
    $display("test modes done");
    // Refused initiates leave the latch alone
    transport_ready <= 1'b0;
    u_tape_host_model.go(9'h001, 1'b1, 2'h0);
    `CHK(formatter_busy_n, 1'b1)
    transport_ready <= 1'b1;
    u_tape_host_model.go(9'h001, 1'b0, 2'h0);
    `CHK(formatter_busy_n, 1'b1)
    bus_rd(CMD_OFS, d);
    `CHK(d[8:0], 9'h1E0)
    $display("test refusal done");
    // Rewind and offline pass through without busy
    for (int w = 0; w < 2; w++) begin
      lo = 0;
      fork
        u_tape_host_model.pulse(w);
        repeat (PW + 4) begin
          @(posedge clk);
          if ((w == 1 ? offline_cmd_n : rewind_cmd_n) === 1'b0) lo++;
          if (formatter_busy_n !== 1'b1) lo += 100;
        end
      join
      `CHK(lo, PW)
    end
    // Negated enable clears a running command whatever the address
    u_tape_host_model.go(9'h000, 1'b1, 2'h0);
    `CHK(formatter_busy_n, 1'b0)
    u_tape_host_model.pulse(2);
    repeat (2) @(posedge clk);
    `CHK(formatter_busy_n, 1'b1)
    $display("test pass-through and enable done");
    stop_test;
  end
endmodule : test_tape_formatter_command_port
`default_nettype wire
